// [verilog/rwf_pkg.sv]
// How it works
// [RULE1] style field picks pulse or level wake
// [RULE2] pulse length code gives 8/16/32/64 cycles
// [RULE3] level wake holds until clear bit written
// [RULE4] software sets receive feature enable first
// [RULE5] unicast enable raises interrupt per unicast frame
// [RULE6] broadcast enable raises interrupt per broadcast frame
// [RULE7] pattern enable raises interrupt on pattern match
// [RULE8] magic enable raises interrupt on magic packet
// [RULE9] wake status flags latch, clear on read
// [RULE10] bad crc and sfd error flags, clear on read
// [RULE11] enabled events drive wake; others only flag
package rwf_pkg;
    // register indices and their byte addresses on the bus
    localparam logic [11:0] CFG_INDEX = 12'h134;
    localparam logic [11:0] STATUS_INDEX = 12'h135;
    localparam logic [11:0] MASK_INDEX = 12'h136;
    localparam logic [11:0] CFG_ADDR = 12'(CFG_INDEX * 4);
    localparam logic [11:0] STATUS_ADDR = 12'(STATUS_INDEX * 4);
    localparam logic [11:0] MASK_ADDR = 12'(MASK_INDEX * 4);
    // config field positions
    localparam int unsigned CFG_MAGIC_BIT = 0;
    localparam int unsigned CFG_PATTERN_BIT = 1;
    localparam int unsigned CFG_BCAST_BIT = 2;
    localparam int unsigned CFG_UCAST_BIT = 4;
    localparam int unsigned CFG_FEATURE_BIT = 7;
    localparam int unsigned CFG_STYLE_BIT = 8;
    localparam int unsigned CFG_LEN_LO = 9;
    localparam int unsigned CFG_CLEAR_BIT = 11;
    // status field positions
    localparam int unsigned ST_MAGIC_BIT = 0;
    localparam int unsigned ST_PATTERN_BIT = 1;
    localparam int unsigned ST_BCAST_BIT = 2;
    localparam int unsigned ST_UCAST_BIT = 4;
    localparam int unsigned ST_CRC_BIT = 6;
    localparam int unsigned ST_SFD_BIT = 7;
    // reset values and writable bits
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WRITABLE = 16'h0797;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // wake output styles
    localparam logic STYLE_PULSE = 1'h0;
    localparam logic STYLE_LEVEL = 1'h1;
    // shortest wake pulse in clock cycles, doubled per length code
    localparam logic [6:0] WAKE_PULSE_BASE = 7'h08;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // wake output state
    typedef enum logic [1:0]
    {
        WK_IDLE = 2'b00,
        WK_PULSE = 2'b01,
        WK_LEVEL = 2'b10
    } rwf_wake_state_e;
endpackage

// [verilog/rwf_sticky_flags.sv]
`timescale 1ns/1ps
// sticky event flags, all cleared by one read strobe; a set wins over the clear
module rwf_sticky_flags
    import rwf_pkg::*;
#(
    parameter int unsigned WIDTH = 8
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // events and clear
    input wire logic [WIDTH-1:0] set,
    input wire logic clear_read,
    // flags
    output logic [WIDTH-1:0] flags
);
    genvar i;
    // one flop per flag
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_flag
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    flags[i] <= 1'b0;
                else if (set[i])
                    flags[i] <= 1'b1; // RULE9
                else if (clear_read)
                    flags[i] <= 1'b0; // RULE10
            end
        end
    endgenerate
endmodule

// [verilog/rwf_wake_out.sv]
`timescale 1ns/1ps
// wake output generator: timed pulse or held level
module rwf_wake_out
    import rwf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic fire,
    input wire logic style,
    input wire logic [1:0] len_code,
    input wire logic level_clear,
    // wake pin level
    output logic wake_out
);
    rwf_wake_state_e state; // current output state
    logic [6:0] remain; // pulse cycles left minus one
    logic [6:0] pulse_cycles; // pulse length for the current code
    logic [6:0] run_cnt; // helper: cycles high since last fire
    logic [6:0] run_want; // helper: length latched at fire
    logic run_style; // helper: style latched at fire

    // 8, 16, 32 or 64 cycles
    assign pulse_cycles = 7'(WAKE_PULSE_BASE << len_code); // RULE2

    // state and output flop; a fire retriggers and beats a clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= WK_IDLE;
            remain <= 7'h00;
            wake_out <= 1'b0;
        end
        else if (fire)
        begin
            if (style == STYLE_LEVEL) // RULE1
                state <= WK_LEVEL;
            else
                state <= WK_PULSE;
            remain <= pulse_cycles - 7'h01; // RULE2
            wake_out <= 1'b1;
        end
        else
        begin
            case (state)
                WK_PULSE:
                begin
                    // count down, drop after the last cycle
                    if (remain == 7'h00)
                    begin
                        state <= WK_IDLE;
                        wake_out <= 1'b0;
                    end
                    else
                        remain <= remain - 7'h01;
                end
                WK_LEVEL:
                begin
                    // hold until software clears
                    if (level_clear)
                    begin
                        state <= WK_IDLE; // RULE3
                        wake_out <= 1'b0;
                    end
                end
                default:
                begin
                    state <= WK_IDLE;
                    wake_out <= 1'b0;
                end
            endcase
        end
    end

    // helper for the length check
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_cnt <= 7'h00;
            run_want <= 7'h00;
            run_style <= 1'b0;
        end
        else if (fire)
        begin
            run_cnt <= 7'h00;
            run_want <= pulse_cycles;
            run_style <= style;
        end
        else if (wake_out && run_cnt != 7'h7F)
            run_cnt <= run_cnt + 7'h01;
    end

    property p_pulse_len;
        @(posedge aclk) disable iff (!aresetn)
        $fell(wake_out) && run_style == STYLE_PULSE |-> run_cnt == run_want;
    endproperty
    a_pulse_len: assert property (p_pulse_len) // RULE2
        else $error("wake pulse length wrong");

    property p_level_hold;
        @(posedge aclk) disable iff (!aresetn)
        state == WK_LEVEL && !level_clear |=> wake_out;
    endproperty
    a_level_hold: assert property (p_level_hold) // RULE3
        else $error("level wake dropped without clear");

    property p_level_clear;
        @(posedge aclk) disable iff (!aresetn)
        state == WK_LEVEL && level_clear && !fire |=> !wake_out ##1 (!wake_out || $past(fire));
    endproperty
    a_level_clear: assert property (p_level_clear) // RULE3
        else $error("level wake not cleared");

    property p_fire_style;
        @(posedge aclk) disable iff (!aresetn)
        fire |=> wake_out && (state == ($past(style) ? WK_LEVEL : WK_PULSE)) [*1];
    endproperty
    a_fire_style: assert property (p_fire_style) // RULE1
        else $error("wake style not followed");

    c_pulse_long: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(wake_out) && run_want == 7'h40);
    c_level_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        state == WK_LEVEL && level_clear);
endmodule

// [verilog/rwf_rx_wake_filter.sv]
`timescale 1ns/1ps
// receive wake filter: registers, event flags, interrupt and wake pin
module rwf_rx_wake_filter
    import rwf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // one-cycle frame events from the receive path
    input wire logic rx_unicast_frame,
    input wire logic rx_broadcast_frame,
    input wire logic rx_pattern_match,
    input wire logic rx_magic_packet,
    input wire logic rx_bad_crc,
    input wire logic rx_frame_start_error,
    // outputs to the system
    output logic remote_wake,
    output logic irq
);
    // write channel holding
    logic aw_held; // address captured, waiting for data
    logic w_held; // data captured, waiting for address
    logic [11:0] aw_addr; // captured write address
    logic [31:0] w_data; // captured write data
    logic [3:0] w_strb; // captured byte enables
    logic do_write; // write performed this cycle

    // registers
    logic [15:0] rx_filter_config; // config, bit 11 never stored
    logic [7:0] rx_filter_irq_mask; // interrupt mask
    logic [7:0] rx_filter_status; // sticky status flags

    // decoded config fields
    logic unicast_wake_en;
    logic broadcast_wake_en;
    logic pattern_wake_en;
    logic magic_wake_en;
    logic rx_feature_enable;
    logic wake_output_style;
    logic [1:0] wake_pulse_length;
    logic wake_level_clear; // one-cycle pulse from a write of bit 11

    // event handling
    logic [7:0] status_set; // events into the sticky flags
    logic [7:0] wake_enables; // per status bit, wake enable
    logic wake_fire; // an enabled wake event this cycle
    logic status_read; // read of the status register taken
    logic [7:0] irq_pending; // flags allowed onto the interrupt

    // ready when the matching holding slot is free
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    // a read is taken only when no read answer is outstanding
    assign s_axi_arready = !s_axi_rvalid;
    // both halves present and the last response gone
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // capture write address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    // capture write data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    // write response, slave error for unmapped addresses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            // status is read-only but decodes, so writes to it succeed
            if (aw_addr == CFG_ADDR || aw_addr == STATUS_ADDR || aw_addr == MASK_ADDR)
                s_axi_bresp <= RESP_OKAY;
            else
                s_axi_bresp <= RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // config register: byte lanes 0 and 1, only defined bits kept
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_filter_config <= CFG_RESET;
        else if (do_write && aw_addr == CFG_ADDR)
        begin
            if (w_strb[0])
                rx_filter_config[7:0] <= w_data[7:0] & CFG_WRITABLE[7:0];
            if (w_strb[1])
                rx_filter_config[15:8] <= w_data[15:8] & CFG_WRITABLE[15:8];
        end
    end

    // mask register: byte lane 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_filter_irq_mask <= MASK_RESET;
        else if (do_write && aw_addr == MASK_ADDR && w_strb[0])
            rx_filter_irq_mask <= w_data[7:0];
    end

    // self-clearing level clear: exists only in the cycle of the write
    assign wake_level_clear = do_write && aw_addr == CFG_ADDR && w_strb[1]
        && w_data[CFG_CLEAR_BIT]; // RULE3

    // field decode
    assign unicast_wake_en = rx_filter_config[CFG_UCAST_BIT];
    assign broadcast_wake_en = rx_filter_config[CFG_BCAST_BIT];
    assign pattern_wake_en = rx_filter_config[CFG_PATTERN_BIT];
    assign magic_wake_en = rx_filter_config[CFG_MAGIC_BIT];
    assign rx_feature_enable = rx_filter_config[CFG_FEATURE_BIT];
    assign wake_output_style = rx_filter_config[CFG_STYLE_BIT];
    assign wake_pulse_length = rx_filter_config[CFG_LEN_LO+1:CFG_LEN_LO];

    // events feed the flags whether enabled or not; wake and crc
    // detection only run with the receive features on
    always_comb
    begin
        status_set = 8'h00;
        status_set[ST_UCAST_BIT] = rx_feature_enable && rx_unicast_frame; // RULE4
        status_set[ST_BCAST_BIT] = rx_feature_enable && rx_broadcast_frame;
        status_set[ST_PATTERN_BIT] = rx_feature_enable && rx_pattern_match;
        status_set[ST_MAGIC_BIT] = rx_feature_enable && rx_magic_packet; // RULE9
        status_set[ST_CRC_BIT] = rx_feature_enable && rx_bad_crc; // RULE10
        status_set[ST_SFD_BIT] = rx_frame_start_error; // RULE10
    end

    // wake enable per status bit; error flags never wake
    always_comb
    begin
        wake_enables = 8'h00;
        wake_enables[ST_UCAST_BIT] = unicast_wake_en; // RULE5
        wake_enables[ST_BCAST_BIT] = broadcast_wake_en; // RULE6
        wake_enables[ST_PATTERN_BIT] = pattern_wake_en; // RULE7
        wake_enables[ST_MAGIC_BIT] = magic_wake_en; // RULE8
    end

    // only enabled events drive the wake pin
    assign wake_fire = |(status_set & wake_enables); // RULE11

    // read of the status register clears it
    assign status_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_ADDR;

    // sticky flags
    rwf_sticky_flags #(
        .WIDTH(8)
    ) u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(status_set),
        .clear_read(status_read),
        .flags(rx_filter_status)
    );

    // wake pin generator
    rwf_wake_out u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(wake_fire),
        .style(wake_output_style),
        .len_code(wake_pulse_length),
        .level_clear(wake_level_clear),
        .wake_out(remote_wake)
    );

    // interrupt: wake flags need their enable and the mask, errors the mask
    assign irq_pending = rx_filter_status & rx_filter_irq_mask
        & (wake_enables | 8'hC0); // RULE5 RULE6 RULE7 RULE8

    // level interrupt output from a flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |irq_pending;
    end

    // read data path, value sampled when the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                // bit 11 reads back as zero, it is never stored
                CFG_ADDR:
                    s_axi_rdata <= {16'h0000, rx_filter_config};
                STATUS_ADDR:
                    s_axi_rdata <= {24'h000000, rx_filter_status}; // RULE9
                MASK_ADDR:
                    s_axi_rdata <= {24'h000000, rx_filter_irq_mask};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    property p_ucast_irq;
        @(posedge aclk) disable iff (!aresetn)
        rx_unicast_frame && rx_feature_enable && unicast_wake_en
            && rx_filter_irq_mask[ST_UCAST_BIT] && !status_read |=> ##1 irq;
    endproperty
    a_ucast_irq: assert property (p_ucast_irq) // RULE5
        else $error("unicast frame raised no interrupt");

    property p_bcast_irq;
        @(posedge aclk) disable iff (!aresetn)
        rx_broadcast_frame && rx_feature_enable && broadcast_wake_en
            && rx_filter_irq_mask[ST_BCAST_BIT] && !status_read |-> ##2 irq;
    endproperty
    a_bcast_irq: assert property (p_bcast_irq) // RULE6
        else $error("broadcast frame raised no interrupt");

    property p_pattern_irq;
        @(posedge aclk) disable iff (!aresetn)
        rx_pattern_match && rx_feature_enable && pattern_wake_en
            && rx_filter_irq_mask[ST_PATTERN_BIT] |=> rx_filter_status[ST_PATTERN_BIT]
            ##1 irq || $past(status_read);
    endproperty
    a_pattern_irq: assert property (p_pattern_irq) // RULE7
        else $error("pattern match raised no interrupt");

    property p_magic_wake;
        @(posedge aclk) disable iff (!aresetn)
        rx_magic_packet && rx_feature_enable && magic_wake_en |=> remote_wake;
    endproperty
    a_magic_wake: assert property (p_magic_wake) // RULE8
        else $error("magic packet gave no wake");

    property p_no_wake_disabled;
        @(posedge aclk) disable iff (!aresetn)
        !remote_wake && !wake_fire |=> !remote_wake;
    endproperty
    a_no_wake_disabled: assert property (p_no_wake_disabled) // RULE11
        else $error("wake rose without an enabled event");

    property p_read_clears;
        @(posedge aclk) disable iff (!aresetn)
        status_read && status_set == 8'h00 |=> rx_filter_status == 8'h00 && s_axi_rvalid;
    endproperty
    a_read_clears: assert property (p_read_clears) // RULE9
        else $error("status not cleared by read");

    property p_error_flags;
        @(posedge aclk) disable iff (!aresetn)
        rx_frame_start_error || (rx_bad_crc && rx_feature_enable)
            |=> rx_filter_status[ST_SFD_BIT] || rx_filter_status[ST_CRC_BIT];
    endproperty
    a_error_flags: assert property (p_error_flags) // RULE10
        else $error("error flag not latched");

    // frame start errors flag even with the receive features off
    property p_sfd_flag;
        @(posedge aclk) disable iff (!aresetn)
        rx_frame_start_error |=> rx_filter_status[ST_SFD_BIT];
    endproperty
    a_sfd_flag: assert property (p_sfd_flag) // RULE10
        else $error("frame start error flag not latched");

    property p_irq_follows;
        @(posedge aclk) disable iff (!aresetn)
        irq_pending == 8'h00 |=> !irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt high with nothing pending");

    c_write_cfg: cover property (@(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr == CFG_ADDR);
    c_status_read: cover property (@(posedge aclk) disable iff (!aresetn)
        status_read && rx_filter_status != 8'h00);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule

// [dv/rwf_host_model.sv]
`timescale 1ns/1ps
// host side: watches the wake pin and the interrupt, never drives the device
module rwf_host_model
    import rwf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pins from the device
    input wire logic remote_wake,
    input wire logic irq,
    // observations
    output logic [7:0] last_len,
    output logic [7:0] irq_rises
);
    logic [7:0] run_len; // cycles the wake pin has been high so far
    logic irq_q; // interrupt level one cycle ago
    // pulse width meter: a finished run is kept until the next one ends
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_len <= 8'h00;
            last_len <= 8'h00;
        end
        else if (remote_wake)
            run_len <= run_len + 8'h01;
        else if (run_len != 8'h00)
        begin
            last_len <= run_len;
            run_len <= 8'h00;
        end
    end
    // interrupt edge counter, a host only reacts to the rise
    always_ff @(posedge aclk)
    begin
        irq_q <= aresetn & irq;
        if (!aresetn)
            irq_rises <= 8'h00;
        else if (irq && !irq_q)
            irq_rises <= irq_rises + 8'h01;
    end
endmodule

// [dv/tb_rwf_rx_wake_filter.sv]
`timescale 1ns/1ps
// self-checking bench for the receive wake filter
module tb_rwf_rx_wake_filter
    import rwf_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] ev = 8'h00; // frame events, laid out like the status register
    logic awready, wready, bvalid, arready, rvalid, remote_wake, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] last_len, irq_rises;
    int n_mismatch = 0;
    int cmp_count = 0;
    // 200 MHz clock
    initial forever #2.5 aclk = ~aclk;
    rwf_rx_wake_filter rwf_rx_wake_filter_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_unicast_frame(ev[4]), .rx_broadcast_frame(ev[2]),
        .rx_pattern_match(ev[1]), .rx_magic_packet(ev[0]), .rx_bad_crc(ev[6]),
        .rx_frame_start_error(ev[7]), .remote_wake(remote_wake), .irq(irq));
    rwf_host_model rwf_host_model_inst (.aclk(aclk), .aresetn(aresetn),
        .remote_wake(remote_wake), .irq(irq), .last_len(last_len), .irq_rises(irq_rises));
    // verdict and end of run
    task automatic summarize();
    begin
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    // one comparison, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // bus write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
    begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    end
    endtask
    // bus read: address held until taken, ready held until the answer
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
    begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    end
    endtask
    // one-cycle event pulse, then a settled look after n edges
    task automatic fire(input logic [7:0] e);
    begin
        @(posedge aclk);
        ev <= e;
        @(posedge aclk);
        ev <= 8'h00;
    end
    endtask
    task automatic settle(input int n);
    begin
        repeat (n) @(posedge aclk);
        #1;
    end
    endtask
    // expected flags: feature enable gates wake and crc, frame start errors always flag
    function automatic logic [7:0] exp_st(input logic [15:0] c, input logic [7:0] e);
        return ((c[7] ? e : 8'h00) & 8'h57) | (e & 8'h80);
    endfunction
    function automatic logic exp_wake(input logic [15:0] c, input logic [7:0] e);
        return c[7] && |(e & c[7:0] & 8'h17);
    endfunction
    function automatic logic exp_irq(input logic [15:0] c, input logic [7:0] m, s);
        return |(s & m & ((c[7:0] & 8'h17) | 8'hC0));
    endfunction
    // hang guard, well beyond the expected few thousand cycles
    initial
    begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
    // main sequence
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] c;
        logic [7:0] m, e, n0;
        logic [7:0] one_ev [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h40, 8'h80};
        void'($urandom(57));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, then an unmapped address
        axi_rd(CFG_ADDR, d, r);
        chk("cfg reset", 32'(CFG_RESET), d);
        axi_rd(STATUS_ADDR, d, r);
        chk("status reset", 32'(STATUS_RESET), d);
        axi_rd(MASK_ADDR, d, r);
        chk("mask reset", 32'(MASK_RESET), d);
        axi_rd(12'h000, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        chk("unmapped data", 32'h0, d);
        axi_wr(12'h000, 32'h0, r);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
        // every pulse length code
        for (int k = 0; k < 4; k++)
        begin
            axi_wr(CFG_ADDR, 32'h81 | (k << 9), r);
            fire(8'h01);
            settle(70);
            chk("pulse len", 32'(8 << k), 32'(last_len));
            axi_rd(STATUS_ADDR, d, r);
            chk("magic flag", 32'h1, d);
        end
        // level style holds until the clear bit, which reads back as zero
        axi_wr(CFG_ADDR, 32'h181, r);
        fire(8'h01);
        settle(100);
        chk("level hold", 32'h1, 32'(remote_wake));
        axi_wr(CFG_ADDR, 32'h981, r);
        settle(2);
        chk("level clear", 32'h0, 32'(remote_wake));
        axi_rd(CFG_ADDR, d, r);
        chk("clear self", 32'h181, d);
        // single events first, then random configs, masks and event mixes
        for (int i = 0; i < 40; i++)
        begin
            c = 16'($urandom) & CFG_WRITABLE;
            m = 8'($urandom) & 8'hD7;
            e = 8'($urandom) & 8'hD7;
            if (i < 6) e = one_ev[i];
            if (i < 6) c = c | 16'h0097;
            axi_wr(CFG_ADDR, 32'(c), r);
            axi_wr(MASK_ADDR, 32'(m), r);
            chk("write resp", 32'(RESP_OKAY), 32'(r));
            axi_rd(STATUS_ADDR, d, r);
            n0 = irq_rises;
            fire(e);
            settle(3);
            chk("wake", 32'(exp_wake(c, e)), 32'(remote_wake));
            chk("irq", 32'(exp_irq(c, m, exp_st(c, e))), 32'(irq));
            chk("irq edge", 32'(exp_irq(c, m, exp_st(c, e))), 32'(irq_rises - n0));
            axi_rd(STATUS_ADDR, d, r);
            chk("status", 32'(exp_st(c, e)), d);
            axi_rd(STATUS_ADDR, d, r);
            chk("status cleared", 32'h0, d);
            settle(0);
            chk("irq cleared", 32'h0, 32'(irq));
            axi_wr(CFG_ADDR, 32'h800, r);
            settle(70);
        end
        summarize();
    end
endmodule
